// *** design/pll_clock_synthesizer_control.sv ***
// Local design decisions: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "pll_synth_defines.svh"

module pll_clock_synthesizer_control
#(
	parameter logic [15:0] REF_TIMEOUT_CYC = 16'(`REF_TIMEOUT_CYC)
)
(
	// clock and reset
	input  wire logic                     clk_in,
	input  wire logic                     rst_n_in,
	// register port
	input  wire pll_synth_pkg::bus_req_t  bus_req_in,
	output logic [15:0]                   rd_data_out,
	// pins
	input  wire logic                     clock_source_strap_in,
	input  wire logic                     external_clock_input_in,
	// clock system outputs
	output logic                          sys_clk_en_out,
	output logic                          sys_reset_n_out,
	output logic                          synth_lock_out,
	output logic                          synth_active_out
);
	import pll_synth_pkg::*;

	// ==================================================
	// control field reset values
	localparam logic [15:0] CTRL_RST_WORD = `SYNTH_CTRL_RST;
	localparam synth_ctrl_t CTRL_RST_FIELDS = '{
		range:   CTRL_RST_WORD[`CTRL_RANGE_BIT],
		postdiv: CTRL_RST_WORD[`CTRL_POSTDIV_BIT],
		modulus: CTRL_RST_WORD[`CTRL_MOD_HI:`CTRL_MOD_LO]
	};

	typedef struct packed {
		logic [1:0]  strap_sync;
		logic [1:0]  ref_sync;
		logic        ref_prev;
		clk_phase_t  phase;
		logic [1:0]  boot_cnt;
		synth_ctrl_t ctrl;
		logic        lock_flag;
		logic [3:0]  lock_cnt;
		logic [9:0]  tick_cnt;
		logic [15:0] nco_inc;
		logic [15:0] ref_idle;
		logic [15:0] rd_data;
		logic        sys_en;
		logic        rst_n;
	} top_state_t;

	top_state_t s_r;
	top_state_t s_nxt;

	logic              synth_on;
	logic              ref_rise;
	logic              nco_tick;
	logic              sys_tick;
	logic [9:0]        target;
	logic signed [10:0] phase_err;
	logic signed [17:0] inc_sum;
	logic              err_small;
	synth_ctrl_t       wr_ctrl;
	logic              loop_change;

	// ==================================================
	// synthesizer oscillator and post-divider
	synth_post_divider u_post_div
	(
		.clk_in       (clk_in),
		.rst_n_in     (rst_n_in),
		.run_in       (synth_on),
		.nco_inc_in   (s_r.nco_inc),
		.postdiv_in   (s_r.ctrl.postdiv),
		.nco_tick_out (nco_tick),
		.sys_tick_out (sys_tick)
	);

	assign synth_on = (s_r.phase == PH_HOLD) || (s_r.phase == PH_RUN);
	assign ref_rise = s_r.ref_sync[1] & ~s_r.ref_prev;

	// ==================================================
	// feedback modulus and phase comparison
	always_comb
	begin
		// modulus and range set feedback count
		// feedback count times 1/8 gives vco ratio
		target = 10'({4'h0, s_r.ctrl.modulus} + 10'h001);
		if (s_r.ctrl.range)
			target = 10'(target << 2);
		phase_err = $signed({1'b0, target}) - $signed({1'b0, s_r.tick_cnt});
		inc_sum = $signed({2'b00, s_r.nco_inc})
			+ 18'($signed(phase_err) <<< `LOOP_GAIN_SHIFT);
		err_small = (phase_err <= `LOCK_TOL) && (phase_err >= -`LOCK_TOL);
	end

	// ==================================================
	// write decode of control fields
	always_comb
	begin
		wr_ctrl.range   = bus_req_in.wdata[`CTRL_RANGE_BIT];
		wr_ctrl.postdiv = bus_req_in.wdata[`CTRL_POSTDIV_BIT];
		wr_ctrl.modulus = bus_req_in.wdata[`CTRL_MOD_HI:`CTRL_MOD_LO];
		loop_change = bus_req_in.wr && (bus_req_in.addr == `SYNTH_CTRL_OFS)
			&& ((wr_ctrl.range != s_r.ctrl.range)
			|| (wr_ctrl.modulus != s_r.ctrl.modulus));
	end

	// ==================================================
	// next state
	always_comb
	begin
		s_nxt = s_r;
		s_nxt.strap_sync = {s_r.strap_sync[0], clock_source_strap_in};
		s_nxt.ref_sync   = {s_r.ref_sync[0], external_clock_input_in};
		s_nxt.ref_prev   = s_r.ref_sync[1];
		s_nxt.sys_en     = 1'b0;
		s_nxt.rd_data    = 16'h0000;

		// reset release and clock source selection
		case (s_r.phase)
			PH_STRAP:
			begin
				s_nxt.rst_n = 1'b0;
				if (s_r.boot_cnt == `STRAP_SETTLE)
				begin
					if (s_r.strap_sync[1])
						s_nxt.phase = PH_HOLD;
					else
						s_nxt.phase = PH_BYPASS;
				end
				else
				begin
					s_nxt.boot_cnt = s_r.boot_cnt + 2'h1;
				end
			end
			PH_HOLD:
			begin
				s_nxt.rst_n = 1'b0;
				if (s_r.lock_flag)
				begin
					s_nxt.phase = PH_RUN;
					s_nxt.rst_n = 1'b1;
				end
			end
			PH_RUN:
			begin
				s_nxt.rst_n = 1'b1;
				s_nxt.sys_en = sys_tick;
			end
			PH_BYPASS:
			begin
				s_nxt.rst_n = 1'b1;
				s_nxt.sys_en = ref_rise;
			end
			default:
			begin
				s_nxt.phase = PH_STRAP;
				s_nxt.rst_n = 1'b0;
			end
		endcase

		// phase detector and loop filter
		if (synth_on)
		begin
			if (nco_tick && (s_r.tick_cnt != 10'h3FF))
				s_nxt.tick_cnt = s_r.tick_cnt + 10'h001;
			if (s_r.ref_idle != REF_TIMEOUT_CYC)
				s_nxt.ref_idle = s_r.ref_idle + 16'h0001;
			if (ref_rise)
			begin
				s_nxt.ref_idle = 16'h0000;
				s_nxt.tick_cnt = nco_tick ? 10'h001 : 10'h000;
				if (inc_sum < 18'sh00001)
					s_nxt.nco_inc = 16'h0001;
				else if (inc_sum > 18'sh0FFFF)
					s_nxt.nco_inc = 16'hFFFF;
				else
					s_nxt.nco_inc = inc_sum[15:0];
				if (err_small)
				begin
					if (s_r.lock_cnt == `LOCK_REFS)
						s_nxt.lock_flag = 1'b1;
					else
						s_nxt.lock_cnt = s_r.lock_cnt + 4'h1;
				end
				else
				begin
					s_nxt.lock_cnt = 4'h0;
					s_nxt.lock_flag = 1'b0;
				end
			end
			else if (s_r.ref_idle == REF_TIMEOUT_CYC)
			begin
				s_nxt.lock_cnt = 4'h0;
				s_nxt.lock_flag = 1'b0;
			end
		end
		else
		begin
			s_nxt.lock_flag = 1'b0;
			s_nxt.lock_cnt = 4'h0;
		end

		// register writes
		if (bus_req_in.wr && (bus_req_in.addr == `SYNTH_CTRL_OFS))
		begin
			s_nxt.ctrl = wr_ctrl;
		end
		// range or modulus change forces relock
		if (loop_change)
		begin
			s_nxt.lock_flag = 1'b0;
			s_nxt.lock_cnt = 4'h0;
		end

		// register reads, data in the following cycle
		if (bus_req_in.rd)
		begin
			case (bus_req_in.addr)
				`SYNTH_CTRL_OFS:
				begin
					s_nxt.rd_data[`CTRL_RANGE_BIT] = s_r.ctrl.range;
					s_nxt.rd_data[`CTRL_POSTDIV_BIT] = s_r.ctrl.postdiv;
					s_nxt.rd_data[`CTRL_MOD_HI:`CTRL_MOD_LO] = s_r.ctrl.modulus;
					s_nxt.rd_data[`CTRL_LOCK_BIT] = s_r.lock_flag;
				end
				`CLK_STATUS_OFS:
				begin
					s_nxt.rd_data[`STAT_SYNTH_BIT] = synth_on;
				end
				default:
				begin
					s_nxt.rd_data = 16'h0000;
				end
			endcase
		end
	end

	// ==================================================
	// state register
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_r <= '0;
			s_r.phase <= PH_STRAP;
			s_r.ctrl <= CTRL_RST_FIELDS;
			s_r.nco_inc <= `NCO_INC_RST;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	// ==================================================
	// outputs
	assign rd_data_out      = s_r.rd_data;
	assign sys_clk_en_out   = s_r.sys_en;
	assign sys_reset_n_out  = s_r.rst_n;
	assign synth_lock_out   = s_r.lock_flag;
	assign synth_active_out = synth_on;

endmodule
`default_nettype wire

// *** design/pll_synth_defines.svh ***
`ifndef PLL_SYNTH_DEFINES_SVH
`define PLL_SYNTH_DEFINES_SVH

// ==================================================
// register map
`define SYNTH_CTRL_OFS    8'h00
`define CLK_STATUS_OFS    8'h02
`define SYNTH_CTRL_RST    16'h3F00

// ==================================================
// control and status register fields
`define CTRL_RANGE_BIT    15
`define CTRL_POSTDIV_BIT  14
`define CTRL_MOD_HI       13
`define CTRL_MOD_LO       8
`define CTRL_LOCK_BIT     3
`define STAT_SYNTH_BIT    0

// ==================================================
// loop and timing
`define CLK_PERIOD_NS     25
`define REF_TIMEOUT_NS    1000000
`define REF_TIMEOUT_CYC   ((`REF_TIMEOUT_NS) / (`CLK_PERIOD_NS))
`define STRAP_SETTLE      2'h3
`define LOOP_GAIN_SHIFT   4
`define LOCK_TOL          11'sh001
`define LOCK_REFS         4'h8
`define NCO_INC_RST       16'h0100
`define NCO_PER_VCO       3'h7
`define POST_DIV4_LAST    2'h3
`define POST_DIV2_LAST    2'h1

`endif

// *** design/pll_synth_pkg.sv ***
package pll_synth_pkg;

	// ==================================================
	// register bus request
	typedef struct packed {
		logic [7:0]  addr;
		logic [15:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_t;

	// ==================================================
	// software fields of the control register
	typedef struct packed {
		logic       range;
		logic       postdiv;
		logic [5:0] modulus;
	} synth_ctrl_t;

	// ==================================================
	// clock system phase
	typedef enum logic [1:0] {
		PH_STRAP  = 2'b00,
		PH_HOLD   = 2'b01,
		PH_RUN    = 2'b10,
		PH_BYPASS = 2'b11
	} clk_phase_t;

endpackage

// *** design/synth_post_divider.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "pll_synth_defines.svh"

module synth_post_divider
(
	// clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// oscillator control
	input  wire logic        run_in,
	input  wire logic [15:0] nco_inc_in,
	input  wire logic        postdiv_in,
	// ticks
	output logic             nco_tick_out,
	output logic             sys_tick_out
);
	import pll_synth_pkg::*;

	typedef struct packed {
		logic [15:0] acc;
		logic [2:0]  vco_div;
		logic [1:0]  post_div;
		logic        nco_tick;
		logic        sys_tick;
	} div_state_t;

	div_state_t s_r;
	div_state_t s_nxt;
	logic [16:0] sum;
	logic        vco_tick;
	logic [1:0]  post_last;

	// ==================================================
	// oscillator, vco divider, post-divider
	always_comb
	begin
		s_nxt = s_r;
		sum = {1'b0, s_r.acc} + {1'b0, nco_inc_in};
		vco_tick = 1'b0;
		post_last = postdiv_in ? `POST_DIV2_LAST : `POST_DIV4_LAST;
		s_nxt.nco_tick = 1'b0;
		s_nxt.sys_tick = 1'b0;
		if (run_in)
		begin
			s_nxt.acc = sum[15:0];
			s_nxt.nco_tick = sum[16];
			if (sum[16])
			begin
				s_nxt.vco_div = s_r.vco_div + 3'h1;
				vco_tick = (s_r.vco_div == `NCO_PER_VCO);
			end
		end
		if (vco_tick)
		begin
			if (s_r.post_div >= post_last)
			begin
				s_nxt.post_div = 2'h0;
				s_nxt.sys_tick = 1'b1;
			end
			else
			begin
				s_nxt.post_div = s_r.post_div + 2'h1;
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign nco_tick_out = s_r.nco_tick;
	assign sys_tick_out = s_r.sys_tick;

endmodule
`default_nettype wire

// *** testbench/pll_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
module pll_checker
#(
	parameter logic [15:0] REF_TIMEOUT_CYC = 16'h00C8
)
(
	// watched ports
	input wire logic                    clk_in,
	input wire logic                    rst_n_in,
	input wire pll_synth_pkg::bus_req_t bus_req_in,
	input wire logic [15:0]             rd_data_out,
	input wire logic                    clock_source_strap_in,
	input wire logic                    external_clock_input_in,
	input wire logic                    sys_clk_en_out,
	input wire logic                    sys_reset_n_out,
	input wire logic                    synth_lock_out,
	input wire logic                    synth_active_out
);
	import pll_synth_pkg::*;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);
	// ====================
	// written fields, pin idle time
	logic [7:0]  fld_r;
	logic [15:0] idle_r;
	logic        rd0;
	logic        wr0;
	assign rd0 = bus_req_in.rd && bus_req_in.addr == 8'h00;
	assign wr0 = bus_req_in.wr && bus_req_in.addr == 8'h00;
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
		begin
			fld_r  <= 8'h3F;
			idle_r <= 16'h0000;
		end
		else
		begin
			if (wr0)
				fld_r <= bus_req_in.wdata[15:8];
			idle_r <= $changed(external_clock_input_in) ? 16'h0000 : idle_r + 16'h0001;
		end
	// ====================
	// properties
	a_ctrl_readback: assert property (
		rd0 |=> rd_data_out == {$past(fld_r), 4'h0, $past(synth_lock_out), 3'h0})
		else $error("bad control read");
	a_status_read: assert property (
		bus_req_in.rd && bus_req_in.addr == 8'h02 |=> rd_data_out[0] == $past(synth_active_out))
		else $error("bad status read");
	a_relock_on_fld: assert property (
		wr0 && {bus_req_in.wdata[15], bus_req_in.wdata[13:8]} != {fld_r[7], fld_r[5:0]}
		|=> !synth_lock_out) else $error("lock kept after loop change");
	a_postdiv_no_relock: assert property (
		wr0 && synth_lock_out && idle_r < (REF_TIMEOUT_CYC >> 1)
		&& {bus_req_in.wdata[15], bus_req_in.wdata[13:8]} == {fld_r[7], fld_r[5:0]}
		|=> synth_lock_out) else $error("lock lost on divider change");
	a_bypass_unlocked: assert property (
		!synth_active_out |-> !synth_lock_out) else $error("lock without synthesizer");
	a_release_after_lock: assert property (
		$rose(sys_reset_n_out) && synth_active_out |-> $past(synth_lock_out))
		else $error("reset released unlocked");
	a_hold_unlocked: assert property (
		synth_active_out && !synth_lock_out && !sys_reset_n_out |=> !sys_reset_n_out)
		else $error("reset released early");
	a_lock_timeout: assert property (
		idle_r > REF_TIMEOUT_CYC + 16'h0008 |-> !synth_lock_out)
		else $error("lock without reference");
endmodule
`default_nettype wire

// *** testbench/ref_clock_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ref_clock_model
(
	// control
	input  wire logic       clk_in,
	input  wire logic       run_in,
	input  wire logic [7:0] half_in,
	// reference pin
	output logic            ref_out
);
	logic [7:0] cnt_r = 8'h00;
	logic       lvl_r = 1'b0;
	assign ref_out = lvl_r;
	// stopped source stands low
	always @(posedge clk_in)
		if (!run_in)
		begin
			cnt_r <= 8'h00;
			lvl_r <= 1'b0;
		end
		else if (cnt_r + 8'h01 >= half_in)
		begin
			cnt_r <= 8'h00;
			lvl_r <= ~lvl_r;
		end
		else
			cnt_r <= cnt_r + 8'h01;
endmodule
`default_nettype wire

// *** testbench/pll_clock_synthesizer_control_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module pll_clock_synthesizer_control_tb_top;
	import pll_synth_pkg::*;
	typedef struct packed {logic [7:0] a; logic [15:0] d; logic [15:0] e;} row_t;
	localparam logic [15:0] TMO = 16'h00C8;
	logic        clk_in = 1'b0;
	logic        rst_n_in = 1'b0;
	bus_req_t    bus_req_in = 26'h0000000;
	logic        strap = 1'b1;
	logic        ref_run = 1'b1;
	logic [7:0]  half = 8'h32;
	logic        ref_pin;
	logic [15:0] rd_data_out;
	logic        sys_clk_en_out;
	logic        sys_reset_n_out;
	logic        synth_lock_out;
	logic        synth_active_out;
	logic [15:0] q;
	int          n_mismatch = 0;
	int          checks = 0;
	row_t        rows [4] = '{'{8'h00, 16'h7F08, 16'h7F00}, '{8'h04, 16'hFFFF, 16'h0000},
		'{8'h00, 16'h00FF, 16'h0000}, '{8'h00, 16'h3F00, 16'h3F00}};
	always #12.5 clk_in = ~clk_in;
	ref_clock_model u_ref (.clk_in(clk_in), .run_in(ref_run), .half_in(half), .ref_out(ref_pin));
	pll_clock_synthesizer_control #(.REF_TIMEOUT_CYC(TMO)) dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_req_in(bus_req_in),
		.rd_data_out(rd_data_out), .clock_source_strap_in(strap),
		.external_clock_input_in(ref_pin), .sys_clk_en_out(sys_clk_en_out),
		.sys_reset_n_out(sys_reset_n_out), .synth_lock_out(synth_lock_out),
		.synth_active_out(synth_active_out));
	// ====================
	// tasks
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
		checks++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
		end
	endtask
	task automatic conclude();
		$display("mismatches %0d checks %0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk_in);
		bus_req_in <= '{a, d, 1'b1, 1'b0};
		@(posedge clk_in);
		bus_req_in <= '{a, d, 1'b0, 1'b0};
	endtask
	task automatic rd(input logic [7:0] a, output logic [15:0] v);
		@(posedge clk_in);
		bus_req_in <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge clk_in);
		bus_req_in <= '{a, 16'h0000, 1'b0, 1'b0};
		@(negedge clk_in);
		v = rd_data_out;
	endtask
	task automatic wait_lock();
		int i;
		for (i = 0; i < 30000 && synth_lock_out !== 1'b1; i++)
			@(negedge clk_in);
		if (synth_lock_out !== 1'b1)
		begin
			chk(16'h0000, 16'h0001, "lock wait");
			conclude();
		end
	endtask
	task automatic rate(input int lo, input int hi);
		int c;
		c = 0;
		repeat (400) @(negedge clk_in) c += (sys_clk_en_out === 1'b1);
		chk(16'(c >= lo && c <= hi), 16'h0001, "tick rate");
	endtask
	// ====================
	// sequence
	initial
	begin
		repeat (10) @(posedge clk_in);
		chk({12'h000, sys_clk_en_out, sys_reset_n_out, synth_lock_out, synth_active_out},
			16'h0000, "reset outs");
		rst_n_in <= 1'b1;
		rd(8'h00, q);
		chk(q, 16'h3F00, "ctrl reset");
		// strap is taken four edges after release
		repeat (4) @(posedge clk_in);
		rd(8'h02, q);
		chk(q, 16'h0001, "status synth");
		chk({15'h0000, sys_reset_n_out}, 16'h0000, "held");
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d);
			rd(rows[i].a, q);
			chk(q, rows[i].e, "readback");
		end
		wait_lock();
		@(negedge clk_in);
		chk({15'h0000, sys_reset_n_out}, 16'h0001, "released");
		rd(8'h00, q);
		chk(q, 16'h3F08, "lock bit");
		rate(7, 9);
		wr(8'h00, 16'h7F00);
		@(negedge clk_in);
		chk({15'h0000, synth_lock_out}, 16'h0001, "no relock");
		rate(15, 17);
		// settings kept under the clock maximum
		wr(8'h00, 16'h8700);
		@(negedge clk_in);
		chk({15'h0000, synth_lock_out}, 16'h0000, "relock");
		wait_lock();
		rate(3, 5);
		@(posedge clk_in);
		ref_run <= 1'b0;
		repeat (TMO + 16'h0032) @(negedge clk_in);
		chk({14'h0000, synth_lock_out, sys_reset_n_out}, 16'h0001, "ref lost");
		@(posedge clk_in);
		rst_n_in <= 1'b0;
		strap <= 1'b0;
		half <= 8'h05;
		ref_run <= 1'b1;
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		repeat (20) @(negedge clk_in);
		chk({14'h0000, synth_active_out, sys_reset_n_out}, 16'h0001, "bypass");
		rd(8'h02, q);
		chk(q, 16'h0000, "status ext");
		rate(39, 41);
		conclude();
	end
endmodule
bind pll_clock_synthesizer_control pll_checker #(.REF_TIMEOUT_CYC(REF_TIMEOUT_CYC)) u_chk (
	.clk_in(clk_in), .rst_n_in(rst_n_in), .bus_req_in(bus_req_in), .rd_data_out(rd_data_out),
	.clock_source_strap_in(clock_source_strap_in),
	.external_clock_input_in(external_clock_input_in), .sys_clk_en_out(sys_clk_en_out),
	.sys_reset_n_out(sys_reset_n_out), .synth_lock_out(synth_lock_out),
	.synth_active_out(synth_active_out));
`default_nettype wire
